// [rtl/rsr_master.sv]
`timescale 1ns/100ps
`default_nettype none
module rsr_master #(
  parameter int RING_W = 160,
  parameter int ID_LEN = 16,
  parameter int GAP_BITS = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // ring side
  rsr_ring_if.master ring,
  // user control
  input wire logic start_id_in,
  input wire logic run_in,
  // user data
  input wire logic [RING_W-1:0] out_data_in,
  output logic [RING_W-1:0] in_data_out,
  output logic [ID_LEN-1:0] id_data_out,
  // status
  output logic lb_err_out,
  output logic busy_out,
  output logic cyc_done_out
);
  // frame body is as wide as the longer of the data and identity chains
  localparam int FW = (RING_W > ID_LEN) ? RING_W : ID_LEN;
  localparam int SH_W = FW + rsr_pkg::LB_W;
  localparam int CW = $clog2(SH_W + 1);
  localparam int TW = $clog2(rsr_pkg::BIT_CYC);
  localparam int GW = $clog2(GAP_BITS + 1);

  // ring-wide ceilings
  if (RING_W < 1 || RING_W > rsr_pkg::MAX_POINTS ||
      ID_LEN < rsr_pkg::ID_W ||
      ID_LEN % rsr_pkg::ID_W != 0 ||
      ID_LEN / rsr_pkg::ID_W > rsr_pkg::MAX_DEVICES || GAP_BITS < 1)
  begin : g_chk
    $error("ring size parameters out of range");
  end

  rsr_pkg::rsr_mst_state_e st_q; // sequencer state
  logic [TW-1:0] timer_q; // bit period timer
  logic tick; // last clock of a bit period
  logic [GW-1:0] gap_q; // bit periods until next data cycle
  logic id_pend_q; // identification cycle owed
  logic id_cyc_q; // current cycle is identification
  logic [SH_W-1:0] tx_q; // outgoing frame
  logic [SH_W-1:0] rx_q; // returned frame
  logic [CW-1:0] cnt_q; // bits shifted so far
  logic [CW-1:0] last_q; // index of the final bit
  logic start; // cycle begins
  logic fin; // latch issued
  logic shift_q;
  logic data_q;
  logic latch_q;
  logic mode_q;

  // free-running bit timer paces the ring at its baud rate
  assign tick = (timer_q == TW'(rsr_pkg::BIT_CYC - 1));
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      timer_q <= '0;
    else if (tick)
      timer_q <= '0;
    else
      timer_q <= timer_q + 1'b1;
  end

  // hold off one clock after a latch so the mode level can drop first
  assign start = (st_q == rsr_pkg::RSR_IDLE) && !latch_q &&
                 (id_pend_q || (run_in && gap_q == '0));
  assign fin = (st_q == rsr_pkg::RSR_LATCH) && tick &&
               (id_cyc_q || ring.n2m_rdy);

  // sequencer
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      st_q <= rsr_pkg::RSR_IDLE;
    else
      case (st_q)
        rsr_pkg::RSR_IDLE:
          if (start)
            st_q <= rsr_pkg::RSR_SETUP;
        // the rest of the current bit period, up to the next tick, lets the mode settle in every node
        rsr_pkg::RSR_SETUP:
          if (tick)
            st_q <= rsr_pkg::RSR_SHIFT;
        rsr_pkg::RSR_SHIFT:
          if (tick && cnt_q == last_q)
            st_q <= rsr_pkg::RSR_LATCH;
        rsr_pkg::RSR_LATCH:
          if (fin)
            st_q <= rsr_pkg::RSR_IDLE;
        default:
          st_q <= rsr_pkg::RSR_IDLE;
      endcase
  end

  // identification owed from reset and on request; request wins
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      id_pend_q <= 1'b1;
    else if (start_id_in)
      id_pend_q <= 1'b1;
    else if (start)
      id_pend_q <= 1'b0;
  end

  // interval between cyclic data cycles
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      gap_q <= '0;
    else if (fin)
      gap_q <= GW'(GAP_BITS);
    else if (st_q == rsr_pkg::RSR_IDLE && tick && gap_q != '0)
      gap_q <= gap_q - 1'b1;
  end

  // frame registers: loop-back word first, then outputs
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      id_cyc_q <= 1'b0;
      tx_q <= '0;
      rx_q <= '0;
      cnt_q <= '0;
      last_q <= '0;
    end
    else if (start)
    begin
      id_cyc_q <= id_pend_q;
      // frame is left-aligned so its first bit sits at the top
      tx_q <= id_pend_q ? {rsr_pkg::LB_WORD, {FW{1'b0}}}
                        : (SH_W'({rsr_pkg::LB_WORD, out_data_in})
                           << (FW - RING_W));
      cnt_q <= '0;
      last_q <= id_pend_q ? CW'(ID_LEN + rsr_pkg::LB_W - 1)
                          : CW'(RING_W + rsr_pkg::LB_W - 1);
    end
    else if (st_q == rsr_pkg::RSR_SHIFT && tick)
    begin
      // sample the return before the strobe moves it
      tx_q <= {tx_q[SH_W-2:0], 1'b0};
      rx_q <= {rx_q[SH_W-2:0], ring.n2m_data};
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ring drive flops
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      shift_q <= 1'b0;
      data_q <= 1'b0;
      latch_q <= 1'b0;
      mode_q <= 1'b0;
    end
    else
    begin
      shift_q <= (st_q == rsr_pkg::RSR_SHIFT) && tick;
      if (st_q == rsr_pkg::RSR_SHIFT && tick)
        data_q <= tx_q[SH_W-1];
      latch_q <= fin;
      // mode stays up through the latch so nodes tell the cycles apart
      if (start)
        mode_q <= id_pend_q;
      else if (latch_q)
        mode_q <= 1'b0;
    end
  end
  assign ring.m2n_shift = shift_q;
  assign ring.m2n_data = data_q;
  assign ring.m2n_latch = latch_q;
  assign ring.m2n_id_mode = mode_q;

  // results captured as the cycle closes
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      in_data_out <= '0;
      id_data_out <= '0;
      lb_err_out <= 1'b0;
      cyc_done_out <= 1'b0;
    end
    else
    begin
      cyc_done_out <= fin;
      if (fin)
      begin
        lb_err_out <= (rx_q[rsr_pkg::LB_W-1:0] != rsr_pkg::LB_WORD);
        if (id_cyc_q)
          id_data_out <= rx_q[ID_LEN+rsr_pkg::LB_W-1:rsr_pkg::LB_W];
        else
          in_data_out <= rx_q[RING_W+rsr_pkg::LB_W-1:rsr_pkg::LB_W];
      end
    end
  end

  assign busy_out = (st_q != rsr_pkg::RSR_IDLE);
endmodule
`default_nettype wire

// [rtl/rsr_node.sv]
// How it works
// - node inserts register sized by I/O
// - nodes chained in series, end returns
// - only master strobes move bits
// - identity word: type, counts, flags
// - identification cycle at init, on request
// - inputs return while outputs go out
// - at most 20 bytes each way
// - master handles at most 4096 points
// - ring holds at most 512 devices
// - no onward segment: loop path back
// - master repeats data cycles at intervals
// - coupler may cut its onward segment
// - up to 16 input, 16 output modules
// - ring bit rate is 500 kBaud
// - node regenerates signals for next station
// - loop-back word first, then output data
// - latch command closes each cycle
// - latch: outputs to periphery, inputs loaded
// - position in ring is the address
`timescale 1ns/100ps
`default_nettype none
module rsr_node #(
  parameter int IN_BYTES = 20,
  parameter int OUT_BYTES = 20,
  parameter int N_IN_MODS = 16,
  parameter int N_OUT_MODS = 16,
  // module type code; value is arbitrary
  parameter logic [3:0] MOD_TYPE = 4'h3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // inbound ring side
  rsr_ring_if.node up,
  // outbound ring side, toward the next station
  output logic next_data_out,
  output logic next_shift_out,
  output logic next_id_mode_out,
  output logic next_latch_out,
  input wire logic next_ret_in,
  input wire logic next_rdy_in,
  input wire logic next_present_in,
  // segment control
  input wire logic seg_en_in,
  output logic seg_off_out,
  // periphery inputs
  input wire logic [8*IN_BYTES-1:0] in_data_in,
  input wire logic periph_err_in,
  // periphery outputs, through the two-entry buffer
  output logic [8*OUT_BYTES-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  // register length follows the wider direction
  localparam int W = 8 * ((IN_BYTES > OUT_BYTES) ? IN_BYTES : OUT_BYTES);
  localparam int OW = 8 * OUT_BYTES;

  // refuse widths the ring cannot carry
  if (IN_BYTES < 1 || IN_BYTES > rsr_pkg::MAX_BYTES ||
      OUT_BYTES < 1 || OUT_BYTES > rsr_pkg::MAX_BYTES)
  begin : g_chk_bytes
    $error("node data width out of range");
  end
  // refuse more modules than the coupler can serve
  if (N_IN_MODS < 0 || N_IN_MODS > rsr_pkg::MAX_MODS ||
      N_OUT_MODS < 0 || N_OUT_MODS > rsr_pkg::MAX_MODS)
  begin : g_chk_mods
    $error("module count out of range");
  end

  // process data shift register
  logic [W-1:0] data_q;
  // identity shift register
  logic [rsr_pkg::ID_W-1:0] id_sh_q;
  // assembled identity word
  logic [rsr_pkg::ID_W-1:0] id_word;
  // bit this node pushes onward on the next strobe
  logic msb;
  // loop the ring back here
  logic loop_back;
  // return path flop
  logic ret_q;
  // onward repeater flops
  logic nx_data_q;
  logic nx_shift_q;
  logic nx_mode_q;
  logic nx_latch_q;
  // output buffer storage and pointers
  logic [OW-1:0] buf_q [rsr_pkg::BUF_DEPTH];
  logic wr_q;
  logic rd_q;
  logic [1:0] cnt_q;
  // buffer handshakes
  logic push;
  logic pop;
  logic buf_full;

  // segment cut by control or by a missing onward line
  assign loop_back = !(seg_en_in && next_present_in);
  assign seg_off_out = loop_back;

  // identity word from build parameters and live flags
  always_comb
  begin
    id_word = '0;
    id_word[rsr_pkg::ID_IN_LSB +: rsr_pkg::CNT_W] =
      rsr_pkg::CNT_W'(IN_BYTES);
    id_word[rsr_pkg::ID_OUT_LSB +: rsr_pkg::CNT_W] =
      rsr_pkg::CNT_W'(OUT_BYTES);
    id_word[rsr_pkg::ID_TYPE_LSB +: rsr_pkg::TYPE_W] = MOD_TYPE;
    id_word[rsr_pkg::ID_SEG_OFF_BIT] = loop_back;
    id_word[rsr_pkg::ID_ERR_BIT] = periph_err_in;
  end

  // the identity register sits in the ring only during identification
  assign msb = up.m2n_id_mode ? id_sh_q[rsr_pkg::ID_W-1] : data_q[W-1];

  // identity register: reloads while idle, shifts in identification
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      id_sh_q <= '0;
    end
    else if (!up.m2n_id_mode)
    begin
      // fresh flags for every identification cycle
      id_sh_q <= id_word;
    end
    else if (up.m2n_shift)
    begin
      // one bit per master strobe
      id_sh_q <= {id_sh_q[rsr_pkg::ID_W-2:0], up.m2n_data};
    end
  end

  // data register: shifts on strobes, swaps with periphery on latch
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      data_q <= '0;
    end
    else if (!up.m2n_id_mode && up.m2n_shift)
    begin
      // inputs leave at the top as outputs enter at the bottom
      data_q <= {data_q[W-2:0], up.m2n_data};
    end
    else if (!up.m2n_id_mode && up.m2n_latch)
    begin
      // sample fresh periphery inputs for the next cycle
      data_q <= W'(in_data_in);
    end
  end

  // push the delivered outputs on a data-cycle latch
  assign push = up.m2n_latch && !up.m2n_id_mode && !buf_full;
  assign pop = out_valid_out && out_ready_in;
  assign buf_full = (cnt_q == 2'(rsr_pkg::BUF_DEPTH));

  // buffer storage, one flop bank per entry
  for (genvar e = 0; e < rsr_pkg::BUF_DEPTH; e++)
  begin : g_buf
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
      if (!resetn_in)
      begin
        buf_q[e] <= '0;
      end
      else if (push && (wr_q == 1'(e)))
      begin
        buf_q[e] <= data_q[OW-1:0];
      end
    end
  end

  // buffer pointers and fill count
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'b00;
    end
    else
    begin
      if (push)
      begin
        wr_q <= !wr_q;
      end
      if (pop)
      begin
        rd_q <= !rd_q;
      end
      // simultaneous push and pop leaves the count alone
      if (push && !pop)
      begin
        cnt_q <= cnt_q + 2'b01;
      end
      else if (pop && !push)
      begin
        cnt_q <= cnt_q - 2'b01;
      end
    end
  end

  // buffer read side
  assign out_valid_out = (cnt_q != 2'b00);
  assign out_data_out = buf_q[rd_q];

  // ring may latch only when no node would drop a word
  assign up.n2m_rdy = !buf_full && (loop_back || next_rdy_in);

  // return path: own register when last, else the onward return
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      ret_q <= 1'b0;
    end
    else if (loop_back)
    begin
      ret_q <= msb;
    end
    else
    begin
      ret_q <= next_ret_in;
    end
  end
  assign up.n2m_data = ret_q;

  // repeater toward the next station, one clock late
  // the pre-shift bit travels with its strobe, so chaining holds
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      nx_data_q <= 1'b0;
      nx_shift_q <= 1'b0;
      nx_mode_q <= 1'b0;
      nx_latch_q <= 1'b0;
    end
    else if (loop_back)
    begin
      // a cut segment sees no strobes at all
      nx_data_q <= 1'b0;
      nx_shift_q <= 1'b0;
      nx_mode_q <= 1'b0;
      nx_latch_q <= 1'b0;
    end
    else
    begin
      nx_data_q <= msb;
      nx_shift_q <= up.m2n_shift;
      nx_mode_q <= up.m2n_id_mode;
      // identification latches pass on even when a buffer is full
      nx_latch_q <= up.m2n_latch &&
                    (up.m2n_id_mode || up.n2m_rdy);
    end
  end

  // onward pins; no address anywhere, position alone decides
  assign next_data_out = nx_data_q;
  assign next_shift_out = nx_shift_q;
  assign next_id_mode_out = nx_mode_q;
  assign next_latch_out = nx_latch_q;
endmodule
`default_nettype wire

// [rtl/rsr_pkg.sv]
package rsr_pkg;
  // system clock and serial ring rate
  localparam int CLK_KHZ = 250000;
  localparam int BAUD_KBAUD = 500;
  // clock cycles in one ring bit period
  localparam int BIT_CYC = CLK_KHZ / BAUD_KBAUD;
  // per-node process data ceiling, in bytes
  localparam int MAX_BYTES = 20;
  // coupler module ceilings
  localparam int MAX_MODS = 16;
  // ring-wide ceilings kept by the master
  localparam int MAX_DEVICES = 512;
  localparam int MAX_POINTS = 4096;
  // identity word layout
  localparam int ID_W = 16;
  localparam int CNT_W = 5;
  localparam int TYPE_W = 4;
  localparam int ID_IN_LSB = 11;
  localparam int ID_OUT_LSB = 6;
  localparam int ID_TYPE_LSB = 2;
  localparam int ID_SEG_OFF_BIT = 1;
  localparam int ID_ERR_BIT = 0;
  // loop-back word sent ahead of every frame
  localparam int LB_W = 16;
  localparam logic [15:0] LB_WORD = 16'hc35a;
  // output buffer depth in the node
  localparam int BUF_DEPTH = 2;
  // master sequencer states
  typedef enum logic [1:0] {
    RSR_IDLE = 2'b00,
    RSR_SETUP = 2'b01,
    RSR_SHIFT = 2'b10,
    RSR_LATCH = 2'b11
  } rsr_mst_state_e;
endpackage

// [rtl/rsr_ring_if.sv]
`timescale 1ns/100ps
`default_nettype none
// ring link between master and first node
interface rsr_ring_if;
  logic m2n_data;    // outbound serial bit
  logic m2n_shift;   // one-cycle shift strobe
  logic m2n_id_mode; // level: identification cycle active
  logic m2n_latch;   // one-cycle end-of-cycle command
  logic n2m_data;    // return serial bit
  logic n2m_rdy;     // level: ring can accept a latch
  modport master (
    output m2n_data, m2n_shift, m2n_id_mode, m2n_latch,
    input n2m_data, n2m_rdy
  );
  modport node (
    input m2n_data, m2n_shift, m2n_id_mode, m2n_latch,
    output n2m_data, n2m_rdy
  );
endinterface
`default_nettype wire

// [verification/rsr_ring_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module rsr_ring_properties #(
  parameter int RING_W = 8,
  parameter int ID_LEN = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // master to node
  input wire logic m2n_data,
  input wire logic m2n_shift,
  input wire logic m2n_id_mode,
  input wire logic m2n_latch,
  // node to master
  input wire logic n2m_data,
  input wire logic n2m_rdy
);
  // clocks since the last strobe, capped so long idles never wrap
  int gap_q;
  // strobes since the last latch command
  int nbits_q;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  // strobe spacing counter
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      gap_q <= rsr_pkg::BIT_CYC;
    else if (m2n_shift)
      gap_q <= 1;
    else if (gap_q < rsr_pkg::BIT_CYC)
      gap_q <= gap_q + 1;
  end
  // frame length counter, cleared by each latch
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      nbits_q <= 0;
    else if (m2n_latch)
      nbits_q <= 0;
    else if (m2n_shift)
      nbits_q <= nbits_q + 1;
  end
  a_shift_pulse: assert property (m2n_shift |=> !m2n_shift)
    else $error("shift strobe longer than one clock");
  a_bit_spacing: assert property (
    m2n_shift |-> gap_q >= rsr_pkg::BIT_CYC)
    else $error("shift strobes closer than one bit period");
  a_latch_ready: assert property (
    (m2n_latch && !m2n_id_mode) |-> $past(n2m_rdy))
    else $error("latch issued while ring not ready");
  a_latch_alone: assert property (
    m2n_latch |-> !m2n_shift ##1 !m2n_latch)
    else $error("latch overlaps a strobe or lasts too long");
  a_data_steady: assert property (
    (m2n_id_mode && !m2n_shift && !$rose(m2n_id_mode)) |->
    $stable(m2n_data))
    else $error("outbound bit moved without a strobe");
  a_mode_close: assert property (
    $fell(m2n_id_mode) |-> $past(m2n_latch))
    else $error("identification mode ended without a latch");
  a_init_ident: assert property (
    $rose(resetn_in) |-> ##[1:4] m2n_id_mode)
    else $error("no identification cycle after reset");
  a_id_length: assert property (
    (m2n_latch && m2n_id_mode) |-> nbits_q == ID_LEN + rsr_pkg::LB_W)
    else $error("identification frame length wrong");
  a_data_length: assert property (
    (m2n_latch && !m2n_id_mode) |-> nbits_q == RING_W + rsr_pkg::LB_W)
    else $error("data frame length wrong");
  c_stall: cover property (!n2m_rdy && !m2n_id_mode && !n2m_data);
endmodule
`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int RW = 8;
  localparam int IDL = 16;
  // clock and reset
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  // master user side
  logic start_id = 1'b0;
  logic run = 1'b0;
  logic [RW-1:0] mst_out = 8'h00;
  logic [RW-1:0] mst_in;
  logic [IDL-1:0] id_data;
  logic lb_err, busy, done;
  // node onward side and the stand-in next station
  logic nx_data, nx_shift, nx_mode, nx_latch;
  logic nx_ret = 1'b0;
  logic nx_present = 1'b0;
  logic seg_en = 1'b0;
  logic seg_off;
  // node periphery
  logic [7:0] pin = 8'h00;
  logic perr = 1'b1;
  logic [7:0] pout;
  logic pvalid;
  logic pready = 1'b0;
  // bookkeeping
  int fails = 0;
  int samples_checked = 0;
  logic seen;
  // 250 mhz clock
  always #2 clk_in = ~clk_in;
  // one-flop repeater; a detached line toggles so stale data shows
  always @(posedge clk_in)
    nx_ret <= nx_present ? nx_data : ~nx_ret;
  rsr_ring_if rsr_ring_if_i ();
  rsr_master #(.RING_W(RW), .ID_LEN(IDL), .GAP_BITS(1)) rsr_master_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .ring(rsr_ring_if_i),
    .start_id_in(start_id), .run_in(run), .out_data_in(mst_out),
    .in_data_out(mst_in), .id_data_out(id_data), .lb_err_out(lb_err),
    .busy_out(busy), .cyc_done_out(done));
  rsr_node #(.IN_BYTES(1), .OUT_BYTES(1)) rsr_node_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .up(rsr_ring_if_i),
    .next_data_out(nx_data), .next_shift_out(nx_shift),
    .next_id_mode_out(nx_mode), .next_latch_out(nx_latch),
    .next_ret_in(nx_ret), .next_rdy_in(1'b1),
    .next_present_in(nx_present), .seg_en_in(seg_en),
    .seg_off_out(seg_off), .in_data_in(pin), .periph_err_in(perr),
    .out_data_out(pout), .out_valid_out(pvalid), .out_ready_in(pready));
  rsr_ring_properties #(.RING_W(RW), .ID_LEN(IDL)) rsr_ring_properties_i (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .m2n_data(rsr_ring_if_i.m2n_data), .m2n_shift(rsr_ring_if_i.m2n_shift),
    .m2n_id_mode(rsr_ring_if_i.m2n_id_mode),
    .m2n_latch(rsr_ring_if_i.m2n_latch),
    .n2m_data(rsr_ring_if_i.n2m_data), .n2m_rdy(rsr_ring_if_i.n2m_rdy));
  // compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    samples_checked++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      fails++;
    end
  endtask
  // bounded wait for the cycle-done pulse, sampled on falling edges
  task automatic wait_done(input int lim);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++)
    begin
      @(negedge clk_in);
      seen = (done === 1'b1);
    end
  endtask
  // check the buffer head, then take it
  task automatic pop(input logic [7:0] exp);
    @(negedge clk_in);
    check(16'(pvalid), 16'h0001, "valid");
    check(16'(pout), 16'(exp), "head");
    @(posedge clk_in);
    pready <= 1'b1;
    @(posedge clk_in);
    pready <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog, sized above the roughly 80k clocks the tests need
  initial
  begin
    repeat (100000) @(posedge clk_in);
    fails++;
    give_verdict();
  end
  initial
  begin
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    // identification runs on its own after reset
    wait_done(20000);
    check(16'(seen), 16'h0001, "identification_cycle");
    check(id_data, 16'h084f, "identity");
    check(16'(lb_err), 16'h0000, "loop-back");
    $display("test identify_after_reset done");
    // two data cycles, periphery holding its outputs back
    @(posedge clk_in);
    run <= 1'b1;
    mst_out <= 8'ha5;
    pin <= 8'h3c;
    wait_done(20000);
    check(16'(seen), 16'h0001, "first data cycle");
    @(posedge clk_in);
    mst_out <= 8'h5a;
    pin <= 8'hc3;
    wait_done(20000);
    check(16'(mst_in), 16'h003c, "returned inputs");
    check(16'(lb_err), 16'h0000, "loop-back");
    $display("test data_cycles done");
    // buffer full: latch must wait and no word is lost
    @(posedge clk_in);
    mst_out <= 8'h96;
    wait_done(16000);
    check(16'(seen), 16'h0000, "latch while full");
    check(16'(rsr_ring_if_i.n2m_rdy), 16'h0000, "ready while full");
    check(16'(busy), 16'h0001, "busy while stalled");
    pop(8'ha5);
    wait_done(2000);
    check(16'(seen), 16'h0001, "latch after drain");
    check(16'(mst_in), 16'h00c3, "returned inputs");
    @(posedge clk_in);
    run <= 1'b0;
    pop(8'h5a);
    pop(8'h96);
    @(negedge clk_in);
    check(16'(pvalid), 16'h0000, "buffer empty");
    check(16'(busy), 16'h0000, "idle with run off");
    $display("test stall_and_drain done");
    // onward segment attached: ring runs through the next station
    @(posedge clk_in);
    nx_present <= 1'b1;
    seg_en <= 1'b1;
    perr <= 1'b0;
    @(negedge clk_in);
    check(16'(seg_off), 16'h0000, "segment on");
    @(posedge clk_in);
    start_id <= 1'b1;
    @(posedge clk_in);
    start_id <= 1'b0;
    wait_done(25000);
    // same counts and type, segment-off and error flags now clear
    check(id_data, 16'h084c, "identity via segment");
    // cut the segment: node loops back and goes quiet onward
    @(posedge clk_in);
    seg_en <= 1'b0;
    repeat (2) @(negedge clk_in);
    check(16'(seg_off), 16'h0001, "segment off");
    check(16'({nx_data, nx_shift}), 16'h0000, "quiet");
    check(16'({nx_mode, nx_latch}), 16'h0000, "quiet");
    $display("test segment done");
    give_verdict();
  end
endmodule
`default_nettype wire
